// File: logic/sgp_pkg.sv
// sgp_pkg: shared constants and types for the sector group protection block
// assumes a 125 MHz system clock; all users write sgp_pkg::name
package sgp_pkg;
	// geometry
	localparam int GROUP_COUNT = 24; // sector groups
	localparam int GROUP_AW = 5; // group index width
	localparam int PWD_W = 64; // password width
	localparam int PWD_SLICE_W = 32; // password programmed one bus word at a time
	localparam int PWD_SLICES = PWD_W / PWD_SLICE_W;
	// boot groups covered by the write-protect pin (outermost of the large bank)
	localparam logic [GROUP_AW-1:0] BOOT_GROUP_LO = 5'h00;
	localparam logic [GROUP_AW-1:0] BOOT_GROUP_HI = 5'h01;
	// reset values
	localparam logic PWD_INIT_BIT = 1'b1; // factory password is all ones
	localparam logic LOCK_CLEAR = 1'b0;
	// timing
	localparam int CLK_MHZ = 125;
	localparam int PWD_CHECK_NS = 2000; // fixed compare delay
	localparam int PWD_CHECK_CYC = (PWD_CHECK_NS * CLK_MHZ + 999) / 1000;
	localparam int PROG_POLL_NS = 1000; // status window, program to protected group
	localparam int PROG_POLL_CYC = (PROG_POLL_NS * CLK_MHZ) / 1000;
	localparam int ERASE_POLL_NS = 50000; // status window, erase to protected group
	localparam int ERASE_POLL_CYC = (ERASE_POLL_NS * CLK_MHZ) / 1000;
	localparam int PWD_TIMEOUT_NS = 1000; // status window, every password program
	localparam int PWD_TIMEOUT_CYC = (PWD_TIMEOUT_NS * CLK_MHZ) / 1000;
	localparam int TMR_W = 13;

	// decoded command codes
	typedef enum logic [3:0] {
		SGP_CMD_NONE,
		SGP_CMD_DYN_SET,
		SGP_CMD_DYN_CLEAR,
		SGP_CMD_PERS_SET,
		SGP_CMD_PERS_ERASE,
		SGP_CMD_FREEZE_SET,
		SGP_CMD_PWD_PROG,
		SGP_CMD_PWD_UNLOCK,
		SGP_CMD_PWD_READ,
		SGP_CMD_PWD_MODE_LOCK,
		SGP_CMD_ARRAY_PROG,
		SGP_CMD_ARRAY_ERASE,
		SGP_CMD_READ_RESET
	} sgp_cmd_type;

	// one command taken from the sequencer
	typedef struct packed {
		sgp_cmd_type cmd;
		logic [GROUP_AW-1:0] group;
		logic [PWD_SLICE_W-1:0] data;
		logic slice;
	} sgp_req_type;

	// status back to the command sequencer
	typedef struct packed {
		logic busy;
		logic status_reads;
		logic refused;
		logic timeout;
		logic array_go;
	} sgp_stat_type;
endpackage : sgp_pkg

// File: logic/sgp_sync.sv
// sgp_sync: two flip-flop synchroniser for asynchronous pin levels
// assumes the pins are static relative to the command sequence
`timescale 1ns/1ps
module sgp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// pins in, synchronised levels out
	input wire logic [W-1:0] async_in,
	input wire logic [W-1:0] rst_val_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r; // first stage, read only by the second

	// two stages; reset value is a constant from the parent port tie
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			meta_r <= rst_val_in;
			sync_out <= rst_val_in;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : sgp_sync

// File: logic/sgp_timer.sv
// sgp_timer: load-and-count-down timer with a done pulse
// assumes loads come from the same clock domain
`timescale 1ns/1ps
module sgp_timer #(
	parameter int W = 13
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// load strobe and count
	input wire logic load_in,
	input wire logic [W-1:0] count_in,
	// state
	output logic run_out,
	output logic done_out
);
	logic [W-1:0] cnt_r; // cycles left

	// count down; done pulses on the last cycle
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			cnt_r <= '0;
			run_out <= 1'b0;
			done_out <= 1'b0;
		end
		else if (load_in)
		begin
			cnt_r <= count_in;
			run_out <= 1'b1;
			done_out <= 1'b0;
		end
		else if (run_out)
		begin
			cnt_r <= cnt_r - 1'b1;
			done_out <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
			run_out <= (cnt_r != {{(W-1){1'b0}}, 1'b1});
		end
		else
		begin
			done_out <= 1'b0;
		end
	end
endmodule : sgp_timer

// File: logic/sgp_protect.sv
// sgp_protect: per-group write protection for a parallel NOR flash
// assumes a command sequencer decodes bus cycles into one-cycle requests,
// and that the array engine obeys array_go / status outputs
//
// Contract
// - one volatile lock per group, freely rewritable
// - dynamic lock matters only when persistent clear
// - set protects group, clear unprotects group
// - dynamic locks cleared on every reset
// - freeze bit cleared at reset outside password mode
// - unfreeze needs reset, then change, then refreeze
// - unprotected only when both lock bits zero
// - freeze blocks persistent changes, not dynamic
// - password mode: freeze set after reset
// - exact 64-bit match clears freeze
// - password bits only program to zero
// - password starts all ones, any order
// - status reads during password program, then read/reset
// - mode lock blocks password read and program
// - each password check waits two microseconds
// - write-protect low refuses both boot groups
// - write-protect high follows boot lock bits
// - supply lockout ignores writes, back to read
// - power-up resets to read, no command accepted
// - write only with chip select, strobe low, enable high
// - protected target unchanged, status window then read
`timescale 1ns/1ps
module sgp_protect #(
	parameter int GROUPS = sgp_pkg::GROUP_COUNT,
	parameter int ERASE_POLL = sgp_pkg::ERASE_POLL_CYC
) (
	// clock and reset (reset pin and power-up, combined upstream)
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// asynchronous pins
	input wire logic write_protect_n_in,
	input wire logic chip_sel_n_in,
	input wire logic write_strobe_n_in,
	input wire logic out_en_n_in,
	input wire logic supply_lockout_in,
	// command request from the sequencer
	input wire logic req_valid_in,
	input wire sgp_pkg::sgp_req_type req_in,
	// nonvolatile state handed in by the array
	input wire logic pwd_mode_in,
	input wire logic pwd_mode_locked_in,
	// status out
	output sgp_pkg::sgp_stat_type stat_out,
	output logic [GROUPS-1:0] group_protected_out,
	output logic persistent_freeze_bit_out,
	output logic [sgp_pkg::PWD_SLICE_W-1:0] pwd_read_out,
	output logic pwd_read_valid_out
);
	localparam logic LOCK_RST = sgp_pkg::LOCK_CLEAR; // freeze value at reset
	// protection state; nonvolatile parts start in their factory state
	logic [GROUPS-1:0] dynamic_group_lock_r; // volatile per group
	logic [GROUPS-1:0] persistent_group_lock_r = '0; // nonvolatile image, shipped clear
	logic persistent_freeze_bit_r;
	logic [sgp_pkg::PWD_W-1:0] pwd_store_r = {sgp_pkg::PWD_W{sgp_pkg::PWD_INIT_BIT}}; // one-time
	logic [sgp_pkg::PWD_W-1:0] pwd_entry_r; // unlock attempt
	logic init_r; // first cycle after reset pending
	// synchronised pins
	logic wp_n_s, cs_n_s, we_n_s, oe_n_s, lockout_s;
	logic write_ok;
	// timer
	logic tmr_load;
	logic [sgp_pkg::TMR_W-1:0] tmr_count;
	logic tmr_run, tmr_done;

	// busy sequence
	typedef enum logic [2:0] {
		SGP_IDLE,
		SGP_PWD_CHECK,
		SGP_PWD_PROG,
		SGP_PWD_HOLD,
		SGP_POLL
	} sgp_state_type;
	sgp_state_type state_r;

	// pins cross into the clock domain before use
	sgp_sync #(
		.W(5)
	) u_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({write_protect_n_in, chip_sel_n_in, write_strobe_n_in,
			out_en_n_in, supply_lockout_in}),
		.rst_val_in(5'h1C), // idle levels, so no false boot lock after reset
		.sync_out({wp_n_s, cs_n_s, we_n_s, oe_n_s, lockout_s})
	);

	// shared wait timer for compare delay and status windows
	sgp_timer #(
		.W(sgp_pkg::TMR_W)
	) u_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.load_in(tmr_load),
		.count_in(tmr_count),
		.run_out(tmr_run),
		.done_out(tmr_done)
	);

	// a write cycle needs select and strobe low with output enable high;
	// the first cycle after reset takes nothing, so power-up lands in read
	assign write_ok = !cs_n_s && !we_n_s && oe_n_s && !lockout_s && !init_r;

	// protection of one group, looked at when a command is accepted
	function automatic logic grp_prot(input logic [sgp_pkg::GROUP_AW-1:0] g,
		input logic [GROUPS-1:0] dyn, input logic [GROUPS-1:0] pers, input logic wp_n);
		logic boot;
		logic p;
		boot = (g == sgp_pkg::BOOT_GROUP_LO) || (g == sgp_pkg::BOOT_GROUP_HI);
		// either bit set protects, regardless of freeze
		p = dyn[g] | pers[g];
		// pin low forces boot groups protected; high leaves their bits in charge
		grp_prot = p | (boot & !wp_n);
	endfunction : grp_prot

	// accept gating for the current request
	logic take;
	logic tgt_prot;
	logic pers_change;
	assign take = req_valid_in && write_ok && (state_r == SGP_IDLE);
	assign tgt_prot = grp_prot(req_in.group, dynamic_group_lock_r,
		persistent_group_lock_r, wp_n_s);
	assign pers_change = (req_in.cmd == sgp_pkg::SGP_CMD_PERS_SET) ||
		(req_in.cmd == sgp_pkg::SGP_CMD_PERS_ERASE);

	// init flag: one idle cycle after reset
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			init_r <= 1'b1;
		else
			init_r <= 1'b0;
	end

	// dynamic locks: any number of set/clear, always allowed
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			dynamic_group_lock_r <= '0;
		else if (take && req_in.cmd == sgp_pkg::SGP_CMD_DYN_SET)
			dynamic_group_lock_r[req_in.group] <= 1'b1;
		else if (take && req_in.cmd == sgp_pkg::SGP_CMD_DYN_CLEAR)
			dynamic_group_lock_r[req_in.group] <= 1'b0;
	end

	// persistent locks: nonvolatile, so reset does not touch them;
	// only changeable while freeze is clear
	always_ff @(posedge clk_in)
	begin
		if (take && !persistent_freeze_bit_r && !sys_rst_in)
		begin
			if (req_in.cmd == sgp_pkg::SGP_CMD_PERS_SET)
				persistent_group_lock_r[req_in.group] <= 1'b1;
			else if (req_in.cmd == sgp_pkg::SGP_CMD_PERS_ERASE)
				persistent_group_lock_r <= '0;
		end
	end

	// freeze bit: reset clears it, or sets it in password mode;
	// no command clears it except a matching password
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			persistent_freeze_bit_r <= LOCK_RST;
		else if (init_r && pwd_mode_in)
			persistent_freeze_bit_r <= 1'b1;
		else if (take && req_in.cmd == sgp_pkg::SGP_CMD_FREEZE_SET)
			persistent_freeze_bit_r <= 1'b1;
		else if (state_r == SGP_PWD_CHECK && tmr_done && pwd_entry_r == pwd_store_r)
			persistent_freeze_bit_r <= 1'b0;
	end

	// password store: starts all ones, bits only go to zero, any slice order;
	// reset keeps it, it stands for a one-time area
	always_ff @(posedge clk_in)
	begin
		// the all-ones start comes from the declaration, never from reset
		if (!sys_rst_in && take && req_in.cmd == sgp_pkg::SGP_CMD_PWD_PROG &&
			!pwd_mode_locked_in)
		begin
			if (req_in.slice)
				pwd_store_r[63:32] <= pwd_store_r[63:32] & req_in.data;
			else
				pwd_store_r[31:0] <= pwd_store_r[31:0] & req_in.data;
		end
	end

	// unlock entry register, loaded slice by slice
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			pwd_entry_r <= '0;
		else if (take && req_in.cmd == sgp_pkg::SGP_CMD_PWD_UNLOCK)
		begin
			if (req_in.slice)
				pwd_entry_r[63:32] <= req_in.data;
			else
				pwd_entry_r[31:0] <= req_in.data;
		end
	end

	// password read port, blocked once the mode lock is set
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pwd_read_out <= '0;
			pwd_read_valid_out <= 1'b0;
		end
		else
		begin
			pwd_read_valid_out <= take && req_in.cmd == sgp_pkg::SGP_CMD_PWD_READ &&
				!pwd_mode_locked_in;
			pwd_read_out <= (pwd_mode_locked_in) ? '0 :
				(req_in.slice ? pwd_store_r[63:32] : pwd_store_r[31:0]);
		end
	end

	// timer load values
	always_comb
	begin
		tmr_load = 1'b0;
		tmr_count = '0;
		if (take && req_in.slice && req_in.cmd == sgp_pkg::SGP_CMD_PWD_UNLOCK)
		begin
			tmr_load = 1'b1;
			tmr_count = sgp_pkg::TMR_W'(sgp_pkg::PWD_CHECK_CYC);
		end
		else if (take && req_in.cmd == sgp_pkg::SGP_CMD_PWD_PROG)
		begin
			tmr_load = 1'b1;
			tmr_count = sgp_pkg::TMR_W'(sgp_pkg::PWD_TIMEOUT_CYC);
		end
		else if (take && tgt_prot && req_in.cmd == sgp_pkg::SGP_CMD_ARRAY_PROG)
		begin
			tmr_load = 1'b1;
			tmr_count = sgp_pkg::TMR_W'(sgp_pkg::PROG_POLL_CYC);
		end
		else if (take && tgt_prot && req_in.cmd == sgp_pkg::SGP_CMD_ARRAY_ERASE)
		begin
			tmr_load = 1'b1;
			tmr_count = sgp_pkg::TMR_W'(ERASE_POLL);
		end
	end

	// busy sequence; supply lockout drops straight back to read
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || lockout_s)
			state_r <= SGP_IDLE;
		else
		begin
			case (state_r)
				SGP_IDLE:
					if (tmr_load)
					begin
						if (req_in.cmd == sgp_pkg::SGP_CMD_PWD_UNLOCK)
							state_r <= SGP_PWD_CHECK;
						else if (req_in.cmd == sgp_pkg::SGP_CMD_PWD_PROG)
							state_r <= SGP_PWD_PROG;
						else
							state_r <= SGP_POLL;
					end
				SGP_PWD_CHECK:
					if (tmr_done)
						state_r <= SGP_IDLE;
				SGP_PWD_PROG:
					if (tmr_done)
						state_r <= SGP_PWD_HOLD;
				SGP_PWD_HOLD:
					// status reads persist until read/reset
					if (req_valid_in && write_ok &&
						req_in.cmd == sgp_pkg::SGP_CMD_READ_RESET)
						state_r <= SGP_IDLE;
				SGP_POLL:
					if (tmr_done)
						state_r <= SGP_IDLE;
				default:
					state_r <= SGP_IDLE;
			endcase
		end
	end

	// status and protection map out, all registered
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			stat_out <= '0;
			group_protected_out <= '0;
			persistent_freeze_bit_out <= 1'b0;
		end
		else
		begin
			stat_out.busy <= (state_r != SGP_IDLE) || tmr_load;
			stat_out.status_reads <= (state_r == SGP_PWD_PROG) ||
				(state_r == SGP_PWD_HOLD);
			stat_out.refused <= take && ((pers_change && persistent_freeze_bit_r) ||
				((req_in.cmd == sgp_pkg::SGP_CMD_ARRAY_PROG ||
				req_in.cmd == sgp_pkg::SGP_CMD_ARRAY_ERASE) && tgt_prot));
			// a zero asked to go back to one times out
			stat_out.timeout <= take && req_in.cmd == sgp_pkg::SGP_CMD_PWD_PROG &&
				((req_in.slice ? ~pwd_store_r[63:32] : ~pwd_store_r[31:0]) &
				req_in.data) != '0;
			stat_out.array_go <= take && !tgt_prot &&
				(req_in.cmd == sgp_pkg::SGP_CMD_ARRAY_PROG ||
				req_in.cmd == sgp_pkg::SGP_CMD_ARRAY_ERASE);
			group_protected_out <= grp_map(dynamic_group_lock_r, persistent_group_lock_r,
				wp_n_s);
			persistent_freeze_bit_out <= persistent_freeze_bit_r;
		end
	end

	// full protection map for every group
	function automatic logic [GROUPS-1:0] grp_map(input logic [GROUPS-1:0] dyn,
		input logic [GROUPS-1:0] pers, input logic wp_n);
		grp_map = '0;
		for (int i = 0; i < GROUPS; i++)
			grp_map[i] = grp_prot(sgp_pkg::GROUP_AW'(i), dyn, pers, wp_n);
	endfunction : grp_map
endmodule : sgp_protect

// File: verification/sgp_protect_properties.sv
// sgp_protect_properties: port-level timing checks for the protection block
// assumes it is bound into every sgp_protect instance and sees its ports only
`timescale 1ns/1ps
module sgp_protect_properties #(
	parameter int GROUPS = 24,
	parameter int ERASE_POLL = 6250
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// pins and request
	input wire logic write_protect_n_in,
	input wire logic chip_sel_n_in,
	input wire logic write_strobe_n_in,
	input wire logic out_en_n_in,
	input wire logic supply_lockout_in,
	input wire logic req_valid_in,
	input wire sgp_pkg::sgp_req_type req_in,
	input wire logic pwd_mode_in,
	input wire logic pwd_mode_locked_in,
	// outputs watched
	input wire sgp_pkg::sgp_stat_type stat_out,
	input wire logic [GROUPS-1:0] group_protected_out,
	input wire logic persistent_freeze_bit_out,
	input wire logic [sgp_pkg::PWD_SLICE_W-1:0] pwd_read_out,
	input wire logic pwd_read_valid_out
);
	logic [1:0] pin_cnt_r; // edges the write pins have been open
	logic [1:0] wp_cnt_r; // edges write protect has been low
	logic [2:0] lk_cnt_r; // edges lockout has been high
	logic pins_ok; // write cycle levels on the pins
	logic take; // request that the block must accept
	assign pins_ok = !chip_sel_n_in && !write_strobe_n_in && out_en_n_in && !supply_lockout_in;
	// only count a request once the pin synchronisers have settled
	assign take = req_valid_in && pin_cnt_r >= 2'h2 && pins_ok && !stat_out.busy
		&& !stat_out.status_reads;
	// write pin age, saturating
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || !pins_ok)
			pin_cnt_r <= 2'h0;
		else if (pin_cnt_r != 2'h3)
			pin_cnt_r <= pin_cnt_r + 2'h1;
	end
	// write protect low age, saturating
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || write_protect_n_in)
			wp_cnt_r <= 2'h0;
		else if (wp_cnt_r != 2'h3)
			wp_cnt_r <= wp_cnt_r + 2'h1;
	end
	// lockout age; generous so a running busy sequence has time to be dropped
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || !supply_lockout_in)
			lk_cnt_r <= 3'h0;
		else if (lk_cnt_r != 3'h7)
			lk_cnt_r <= lk_cnt_r + 3'h1;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	reset_clear_a: assert property (disable iff (1'b0) $past(sys_rst_in) |->
		group_protected_out == '0 && !persistent_freeze_bit_out) else $error("locks not clear");
	freeze_low_a: assert property ($fell(sys_rst_in) && !pwd_mode_in |=>
		!persistent_freeze_bit_out) else $error("freeze set outside password mode");
	freeze_pwd_a: assert property ($fell(sys_rst_in) && pwd_mode_in |->
		##[1:2] persistent_freeze_bit_out) else $error("freeze not set in password mode");
	dyn_set_a: assert property (take && req_in.cmd == sgp_pkg::SGP_CMD_DYN_SET |=>
		##1 group_protected_out[$past(req_in.group, 2)]) else $error("set left group open");
	freeze_set_a: assert property (take && req_in.cmd == sgp_pkg::SGP_CMD_FREEZE_SET |=>
		##1 persistent_freeze_bit_out) else $error("freeze set ignored");
	frozen_refuse_a: assert property (take && req_in.cmd == sgp_pkg::SGP_CMD_PERS_SET
		&& persistent_freeze_bit_out |=> stat_out.refused && $stable(group_protected_out))
		else $error("frozen persistent change");
	boot_refuse_a: assert property (take && req_in.cmd == sgp_pkg::SGP_CMD_ARRAY_PROG
		&& req_in.group <= sgp_pkg::BOOT_GROUP_HI && wp_cnt_r >= 2'h2 && !write_protect_n_in
		|=> stat_out.refused && !stat_out.array_go) else $error("boot group written");
	prot_poll_a: assert property (take && req_in.cmd == sgp_pkg::SGP_CMD_ARRAY_PROG
		&& group_protected_out[req_in.group] |=> stat_out.busy[*8] ##[100:140] !stat_out.busy)
		else $error("poll window wrong");
	lockout_idle_a: assert property (lk_cnt_r >= 3'h5 |->
		!stat_out.busy && !stat_out.array_go) else $error("active under lockout");
	pwd_delay_a: assert property (take && req_in.cmd == sgp_pkg::SGP_CMD_PWD_UNLOCK
		&& req_in.slice && persistent_freeze_bit_out |=>
		persistent_freeze_bit_out throughout ##240 1'b1) else $error("check too fast");
	pwd_hide_a: assert property (pwd_mode_locked_in && $past(pwd_mode_locked_in, 2) |->
		pwd_read_out == '0) else $error("password visible");
endmodule : sgp_protect_properties

bind sgp_protect sgp_protect_properties #(.GROUPS(GROUPS), .ERASE_POLL(ERASE_POLL)) chk (
	.clk_in, .sys_rst_in, .write_protect_n_in, .chip_sel_n_in, .write_strobe_n_in,
	.out_en_n_in, .supply_lockout_in, .req_valid_in, .req_in, .pwd_mode_in,
	.pwd_mode_locked_in, .stat_out, .group_protected_out, .persistent_freeze_bit_out,
	.pwd_read_out, .pwd_read_valid_out);

// File: verification/sgp_host.sv
// sgp_host: behavioural host that opens write cycles and strobes requests
// assumes send() is called from a falling clock edge
`timescale 1ns/1ps
module sgp_host (
	// clock and answers from the block
	input wire logic clk_in,
	input wire sgp_pkg::sgp_stat_type stat_in,
	input wire logic [sgp_pkg::PWD_SLICE_W-1:0] pwd_read_in,
	input wire logic pwd_valid_in,
	// pins and request to the block
	output logic chip_sel_n_out,
	output logic write_strobe_n_out,
	output logic out_en_n_out,
	output logic req_valid_out,
	output sgp_pkg::sgp_req_type req_out
);
	sgp_pkg::sgp_stat_type last_stat; // status in the answer cycle
	logic [sgp_pkg::PWD_SLICE_W-1:0] last_rd; // read word in the answer cycle
	logic last_rdv; // read valid pulse in the answer cycle
	// idle bus: deselected, strobe high, output enable low
	initial
	begin
		chip_sel_n_out = 1'b1;
		write_strobe_n_out = 1'b1;
		out_en_n_out = 1'b0;
		req_valid_out = 1'b0;
		req_out = '0;
	end
	// one command; bad picks a pin that spoils the write cycle, 0 for none
	task automatic send(input sgp_pkg::sgp_cmd_type c, input logic [4:0] g,
		input logic [31:0] d, input logic s, input int bad);
		chip_sel_n_out = (bad == 1);
		write_strobe_n_out = (bad == 2);
		out_en_n_out = (bad != 3);
		// pins must cross the synchronisers before the request
		repeat (3) @(negedge clk_in);
		req_valid_out = 1'b1;
		req_out = '{c, g, d, s};
		// answer pulses stand for the one cycle after the taking edge
		@(negedge clk_in);
		last_stat = stat_in;
		last_rd = pwd_read_in;
		last_rdv = pwd_valid_in;
		req_valid_out = 1'b0;
		chip_sel_n_out = 1'b1;
		write_strobe_n_out = 1'b1;
		out_en_n_out = 1'b0;
		// let an edge pass so the next call never redrives in this step
		@(negedge clk_in);
	endtask : send
endmodule : sgp_host

// File: verification/sector_group_protection_bench.sv
// sector_group_protection_bench: lock model against the protection block
// assumes 125 MHz clock, inputs moved on falling edges, short erase window
`timescale 1ns/1ps
module sector_group_protection_bench;
	localparam int G = sgp_pkg::GROUP_COUNT;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic wp_n = 1'b1; // held steady across each command
	logic lockout = 1'b0;
	logic pm = 1'b0; // password mode
	logic pml = 1'b0; // password mode lock bit
	logic cs_n;
	logic we_n;
	logic oe_n;
	logic rv;
	sgp_pkg::sgp_req_type rq;
	sgp_pkg::sgp_stat_type stat;
	logic [G-1:0] map;
	logic frz;
	logic [31:0] rd;
	logic rdv;
	bit [G-1:0] m_dyn; // model of the volatile locks
	bit [G-1:0] m_pers; // model of the persistent locks
	int n_fail = 0;
	int total_checks = 0;
	int seed = 42;
	logic [4:0] g;
	bit s;
	always #4 clk_in = ~clk_in;
	sgp_protect #(.ERASE_POLL(20)) DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.write_protect_n_in(wp_n), .chip_sel_n_in(cs_n), .write_strobe_n_in(we_n),
		.out_en_n_in(oe_n), .supply_lockout_in(lockout), .req_valid_in(rv), .req_in(rq),
		.pwd_mode_in(pm), .pwd_mode_locked_in(pml), .stat_out(stat),
		.group_protected_out(map), .persistent_freeze_bit_out(frz), .pwd_read_out(rd),
		.pwd_read_valid_out(rdv));
	sgp_host host (.clk_in(clk_in), .stat_in(stat), .pwd_read_in(rd), .pwd_valid_in(rdv),
		.chip_sel_n_out(cs_n),
		.write_strobe_n_out(we_n), .out_en_n_out(oe_n), .req_valid_out(rv), .req_out(rq));
	task automatic check_map();
		total_checks++;
		if (map !== (m_dyn | m_pers))
		begin
			n_fail++;
			$display("MISMATCH %0t map %0h exp %0h", $time, map, m_dyn | m_pers);
		end
	endtask : check_map
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string w);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t %s got %0h exp %0h", $time, w, got, exp);
		end
	endtask : check_val
	task automatic cmd(input sgp_pkg::sgp_cmd_type c, input logic [4:0] grp);
		host.send(c, grp, 32'h0, 1'b0, 0);
	endtask : cmd
	// bounded wait for the timer to run out
	task automatic wait_idle();
		int i;
		i = 0;
		while (stat.busy !== 1'b0 && i < 400)
		begin
			@(negedge clk_in);
			i++;
		end
		check_val(stat.busy, 1'b0, "busy stuck");
	endtask : wait_idle
	task automatic do_reset();
		sys_rst_in = 1'b1;
		repeat (20) @(negedge clk_in);
		sys_rst_in = 1'b0;
		m_dyn = '0;
		repeat (3) @(negedge clk_in);
	endtask : do_reset
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	// main sequence
	initial
	begin
		do_reset();
		check_map();
		check_val(frz, 1'b0, "freeze at start");
		for (int i = 0; i < 12; i++)
		begin
			g = 5'($unsigned($random(seed)) % G);
			s = 1'($random(seed));
			cmd(s ? sgp_pkg::SGP_CMD_DYN_SET : sgp_pkg::SGP_CMD_DYN_CLEAR, g);
			m_dyn[g] = s;
			check_map();
		end
		cmd(sgp_pkg::SGP_CMD_PERS_SET, 5'h07);
		m_pers[7] = 1'b1;
		cmd(sgp_pkg::SGP_CMD_DYN_CLEAR, 5'h07);
		m_dyn[7] = 1'b0;
		check_map();
		cmd(sgp_pkg::SGP_CMD_FREEZE_SET, 5'h00);
		check_val(frz, 1'b1, "freeze");
		cmd(sgp_pkg::SGP_CMD_PERS_SET, 5'h09);
		check_val(host.last_stat.refused, 1'b1, "frozen refuse");
		cmd(sgp_pkg::SGP_CMD_DYN_SET, 5'h09);
		m_dyn[9] = 1'b1;
		check_map();
		cmd(sgp_pkg::SGP_CMD_ARRAY_PROG, 5'h07);
		check_val(host.last_stat.refused, 1'b1, "prog refuse");
		wait_idle();
		cmd(sgp_pkg::SGP_CMD_ARRAY_ERASE, 5'h09);
		check_val(host.last_stat.refused, 1'b1, "erase refuse");
		wait_idle();
		cmd(sgp_pkg::SGP_CMD_DYN_CLEAR, 5'h03);
		m_dyn[3] = 1'b0;
		cmd(sgp_pkg::SGP_CMD_ARRAY_PROG, 5'h03);
		check_val(host.last_stat.array_go, 1'b1, "open prog");
		wait_idle();
		// boot groups: unlock both, then lower write protect between commands
		cmd(sgp_pkg::SGP_CMD_DYN_CLEAR, sgp_pkg::BOOT_GROUP_LO);
		cmd(sgp_pkg::SGP_CMD_DYN_CLEAR, sgp_pkg::BOOT_GROUP_HI);
		m_dyn[1:0] = 2'h0;
		wp_n = 1'b0;
		for (int b = 0; b < 2; b++)
		begin
			cmd(sgp_pkg::SGP_CMD_ARRAY_PROG, 5'(b));
			check_val(host.last_stat.refused, 1'b1, "boot refuse");
			wait_idle();
		end
		wp_n = 1'b1;
		cmd(sgp_pkg::SGP_CMD_ARRAY_PROG, sgp_pkg::BOOT_GROUP_LO);
		check_val(host.last_stat.array_go, 1'b1, "boot open");
		wait_idle();
		cmd(sgp_pkg::SGP_CMD_DYN_CLEAR, 5'h14);
		m_dyn[20] = 1'b0;
		for (int b = 1; b < 4; b++)
		begin
			host.send(sgp_pkg::SGP_CMD_DYN_SET, 5'h14, 32'h0, 1'b0, b);
			check_map();
		end
		lockout = 1'b1;
		cmd(sgp_pkg::SGP_CMD_DYN_SET, 5'h14);
		check_map();
		lockout = 1'b0;
		do_reset();
		check_map();
		check_val(frz, 1'b0, "freeze after reset");
		cmd(sgp_pkg::SGP_CMD_PERS_ERASE, 5'h00);
		m_pers = '0;
		check_map();
		pm = 1'b1;
		do_reset();
		check_val(frz, 1'b1, "password freeze");
		cmd(sgp_pkg::SGP_CMD_PWD_READ, 5'h00);
		check_val(host.last_rd, 32'hFFFFFFFF, "factory word");
		check_val(host.last_rdv, 1'b1, "read valid");
		host.send(sgp_pkg::SGP_CMD_PWD_PROG, 5'h00, 32'hFFFF0000, 1'b0, 0);
		check_val(stat.status_reads, 1'b1, "status reads");
		// busy stays up until read/reset, so wait out the program time instead
		repeat (sgp_pkg::PWD_TIMEOUT_CYC + 4) @(negedge clk_in);
		cmd(sgp_pkg::SGP_CMD_READ_RESET, 5'h00);
		check_val(stat.status_reads, 1'b0, "read mode");
		wait_idle();
		host.send(sgp_pkg::SGP_CMD_PWD_PROG, 5'h00, 32'hFFFFFFFF, 1'b0, 0);
		check_val(host.last_stat.timeout, 1'b1, "timeout");
		repeat (sgp_pkg::PWD_TIMEOUT_CYC + 4) @(negedge clk_in);
		cmd(sgp_pkg::SGP_CMD_READ_RESET, 5'h00);
		cmd(sgp_pkg::SGP_CMD_PWD_READ, 5'h00);
		check_val(host.last_rd, 32'hFFFF0000, "stays zero");
		for (int k = 0; k < 2; k++)
		begin
			host.send(sgp_pkg::SGP_CMD_PWD_UNLOCK, 5'h00, k ? 32'hFFFF0000 : 32'hFFFFFFFF, 0, 0);
			host.send(sgp_pkg::SGP_CMD_PWD_UNLOCK, 5'h00, 32'hFFFFFFFF, 1'b1, 0);
			wait_idle();
			check_val(frz, k ? 1'b0 : 1'b1, "unlock");
		end
		pml = 1'b1;
		cmd(sgp_pkg::SGP_CMD_PWD_READ, 5'h00);
		check_val(host.last_rd, 32'h0, "hidden word");
		check_val(host.last_rdv, 1'b0, "read blocked");
		conclude();
	end
	// watchdog: the sequence needs well under 10,000 cycles
	initial
	begin
		#400000;
		n_fail++;
		conclude();
	end
endmodule : sector_group_protection_bench
